//--- design/clkgen_pkg.sv
// types shared by the clock generator
package clkgen_pkg;

    // strap decode of the clock mode pins
    typedef struct packed {
        logic pll_enable_bit;
        logic pll_prescale;
        logic timer_prescale;
        logic [11:0] multiply_factor;
    } strap_cfg_t;

    // derived clock levels leaving the block
    typedef struct packed {
        logic general_system_clock;
        logic baud_gen_clock;
        logic serial_sync_clock;
        logic integration_module_clock;
        logic timer_base_clock;
        logic clock_out_single;
        logic clock_out_double;
    } clocks_t;

    // lock tracking states
    typedef enum logic [1:0] {
        LOCK_WAIT,
        LOCK_ACQUIRE,
        LOCK_DONE
    } lock_state_t;

endpackage

//--- design/clkgen_regs.svh
// register offsets, field positions, reset values and timing counts of the clock generator
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// register byte offsets
`define PLL_CTRL_OFFSET 12'h000
`define DIV_CTRL_OFFSET 12'h004
`define STATUS_OFFSET 12'h008

// pll control fields
`define PLL_MF_LSB 0
`define PLL_MF_MSB 11
`define PLL_EN_BIT 12

// divider control fields
`define DIV_LOW_LSB 0
`define DIV_HIGH_LSB 4
`define DIV_SRC_BIT 7
`define DIV_THR_LSB 8
`define DIV_RRQ_BIT 11
`define DIV_SYNC_LSB 12
`define DIV_AUTO_BIT 15
`define DIV_BRG_LSB 16
`define DIV_WP_BIT 31

// status fields
`define STAT_LOCK_BIT 0
`define STAT_NORMAL_BIT 1
`define STAT_HIGH_BIT 2
`define STAT_MODE_LSB 4
`define STAT_WP_BIT 8

// multiply field values (factor is field + 1)
`define MF_LOW_XTAL 12'h190
`define MF_SYS_IN 12'h001

// reset value of divider control: all divides by 1, normal clocking
`define DIV_CTRL_RESET 32'h0000_0000

// osc prescaler ratio, as a counter width (2**7 = 128)
`define PRESCALE_BITS 7

// lock times in reference clocks
`define LOCK_TYPICAL_CLOCKS 500
`define LOCK_WORST_CLOCKS 2500

// derived clock period at divide by 1, in pclk cycles; first phase length
`define BASE_PERIOD 4
`define KEEP_PHASE 2

`endif

//--- design/pll_clock_generator_slowgo.sv
// pll clock generator with prescaler, low-power divider and slow-go select
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module pll_clock_generator_slowgo #(
    parameter int LOCK_CLOCKS = `LOCK_TYPICAL_CLOCKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic osc_input_pin,
    input wire logic [1:0] clock_mode_pins,
    input wire logic [2:0] interrupt_level,
    input wire logic risc_busy,
    output clkgen_pkg::clocks_t clocks,
    output logic pll_locked
);

    // strap decode: returns pll enable, prescale choices and factor field
    function automatic clkgen_pkg::strap_cfg_t decode_mode(input logic [1:0] mode);
        clkgen_pkg::strap_cfg_t cfg;
        cfg = '0;
        case (mode)
            2'b00:
            begin
                cfg.multiply_factor = `MF_LOW_XTAL;
                cfg.pll_enable_bit = 1'b1;
            end
            2'b01:
            begin
                cfg.pll_enable_bit = 1'b1;
                cfg.timer_prescale = 1'b1;
                cfg.multiply_factor = `MF_SYS_IN;
            end
            2'b10:
            begin
                cfg.pll_enable_bit = 1'b1;
                cfg.pll_prescale = 1'b1;
                cfg.timer_prescale = 1'b1;
                cfg.multiply_factor = `MF_LOW_XTAL;
            end
            default:
            begin
                cfg.pll_enable_bit = 1'b1;
                cfg.multiply_factor = `MF_SYS_IN;
            end
        endcase
        return cfg;
    endfunction

    // period of a derived clock in pclk cycles for a divide select
    function automatic logic [9:0] period_of(input logic [2:0] sel);
        logic [9:0] p;
        p = 10'(`BASE_PERIOD) << sel;
        return p;
    endfunction

    // synchronisers for the pin inputs
    logic [1:0] osc_sync_ff;
    logic [1:0] mode_meta_ff;
    logic [1:0] mode_sync_ff;
    logic osc_prev_ff;

    // strap capture
    logic [1:0] strap_cnt_ff;
    logic [1:0] mode_ff;
    clkgen_pkg::strap_cfg_t cfg_ff;
    clkgen_pkg::strap_cfg_t strap_now;

    // registers
    logic [11:0] mf_ff;
    logic pll_en_ff;
    logic [31:0] div_ctrl_ff;
    logic wp_ff;

    // prescaler and reference tick
    logic [`PRESCALE_BITS-1:0] pre_cnt_ff;
    logic ref_tick;
    logic osc_rise;

    // lock tracking
    clkgen_pkg::lock_state_t lock_state_ff;
    logic [11:0] lock_cnt_ff;
    logic mf_write;

    // derived clock generators: 0 system, 1 baud, 2 sync
    logic [9:0] gen_cnt_ff [3];
    logic [2:0] gen_sel_ff [3];
    logic [2:0] nxt_sel [3];

    // slow-go select
    logic demand;
    logic normal_mode;
    logic high_rate;

    // apb
    logic acc_done;
    logic wr_pll;
    logic wr_div;
    logic mapped;

    // two flops ahead of every pin reader
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_sync_ff <= 2'h0;
            mode_meta_ff <= 2'h3; // pins pull up
            mode_sync_ff <= 2'h3;
        end
        else
        begin
            osc_sync_ff <= {osc_sync_ff[0], osc_input_pin};
            mode_meta_ff <= clock_mode_pins;
            mode_sync_ff <= mode_meta_ff;
        end
    end

    // strap decode of the settled pins
    assign strap_now = decode_mode(mode_sync_ff);

    // strap caught once the synchroniser has settled after release, never again
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_cnt_ff <= 2'h0;
            mode_ff <= 2'h3;
            cfg_ff <= '0;
        end
        else if (strap_cnt_ff != 2'h3)
        begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'h2)
            begin
                mode_ff <= mode_sync_ff;
                cfg_ff <= strap_now;
            end
        end
    end

    // osc edge and the 128 prescaler
    assign osc_rise = osc_sync_ff[1] & ~osc_prev_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_prev_ff <= 1'b0;
            pre_cnt_ff <= '0;
        end
        else
        begin
            osc_prev_ff <= osc_sync_ff[1];
            if (osc_rise)
                pre_cnt_ff <= pre_cnt_ff + {{(`PRESCALE_BITS-1){1'b0}}, 1'b1};
        end
    end

    // pll reference is the raw edge or one edge in 128
    assign ref_tick = osc_rise & (!cfg_ff.pll_prescale || pre_cnt_ff == '1);

    // apb handshake: one wait state, answer registered
    assign acc_done = psel & penable & pready;
    assign wr_pll = acc_done & pwrite & (paddr == `PLL_CTRL_OFFSET);
    assign wr_div = acc_done & pwrite & (paddr == `DIV_CTRL_OFFSET);
    assign mapped = (paddr == `PLL_CTRL_OFFSET) || (paddr == `DIV_CTRL_OFFSET)
        || (paddr == `STATUS_OFFSET);
    assign mf_write = wr_pll;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel & penable & ~pready & ~pwrite)
            begin
                case (paddr)
                    `PLL_CTRL_OFFSET:
                        prdata <= {19'h0, pll_en_ff, mf_ff};
                    `DIV_CTRL_OFFSET:
                        prdata <= div_ctrl_ff;
                    `STATUS_OFFSET:
                        prdata <= {23'h0, wp_ff, 2'h0, mode_ff, 1'b0, high_rate,
                            normal_mode, pll_locked};
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // pll control register, loaded from the strap, then software
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mf_ff <= 12'h000;
            pll_en_ff <= 1'b0;
        end
        else if (strap_cnt_ff == 2'h2)
        begin
            mf_ff <= strap_now.multiply_factor;
            pll_en_ff <= strap_now.pll_enable_bit;
        end
        else if (wr_pll)
        begin
            mf_ff <= pwdata[`PLL_MF_MSB:`PLL_MF_LSB];
            pll_en_ff <= pwdata[`PLL_EN_BIT];
        end
    end

    // divider control; the protect bit can only be set, and then blocks writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_ctrl_ff <= `DIV_CTRL_RESET;
            wp_ff <= 1'b0;
        end
        else if (wr_div && !wp_ff)
        begin
            div_ctrl_ff <= pwdata;
            wp_ff <= pwdata[`DIV_WP_BIT];
        end
    end

    // lock model: halts clocking until enough reference edges after start or retune
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_state_ff <= clkgen_pkg::LOCK_WAIT;
            lock_cnt_ff <= 12'h000;
            pll_locked <= 1'b0;
        end
        else
        begin
            case (lock_state_ff)
                clkgen_pkg::LOCK_WAIT:
                begin
                    if (strap_cnt_ff == 2'h3)
                        lock_state_ff <= clkgen_pkg::LOCK_ACQUIRE;
                end
                clkgen_pkg::LOCK_ACQUIRE:
                begin
                    if (!pll_en_ff || lock_cnt_ff == 12'(LOCK_CLOCKS - 1) && ref_tick)
                    begin
                        lock_state_ff <= clkgen_pkg::LOCK_DONE;
                        pll_locked <= 1'b1;
                    end
                    else if (ref_tick)
                        lock_cnt_ff <= lock_cnt_ff + 12'h001;
                end
                clkgen_pkg::LOCK_DONE:
                begin
                    if (mf_write && pwdata[`PLL_EN_BIT])
                    begin
                        lock_state_ff <= clkgen_pkg::LOCK_ACQUIRE;
                        lock_cnt_ff <= 12'h000;
                        pll_locked <= 1'b0;
                    end
                end
                default:
                    lock_state_ff <= clkgen_pkg::LOCK_WAIT;
            endcase
        end
    end

    // slow-go: demand lifts the system clock off the low rate
    assign demand = (interrupt_level > div_ctrl_ff[`DIV_THR_LSB +: 3])
        || (div_ctrl_ff[`DIV_RRQ_BIT] && risc_busy);
    // auto bit clear: demand means full speed; set: demand means the high rate
    assign normal_mode = !div_ctrl_ff[`DIV_SRC_BIT]
        || (demand && !div_ctrl_ff[`DIV_AUTO_BIT]);
    assign high_rate = !normal_mode && demand;

    // select per generator, read at period end or while halted
    always_comb
    begin
        if (normal_mode)
            nxt_sel[0] = 3'h0;
        else if (high_rate)
            nxt_sel[0] = div_ctrl_ff[`DIV_HIGH_LSB +: 3];
        else
            nxt_sel[0] = div_ctrl_ff[`DIV_LOW_LSB +: 3];
        nxt_sel[1] = div_ctrl_ff[`DIV_BRG_LSB +: 3];
        nxt_sel[2] = div_ctrl_ff[`DIV_SYNC_LSB +: 3];
    end

    // divider counters run off the vco (pclk) and stop while unlocked
    // while locked a new ratio is only taken at wrap so no phase gets cut short by a ratio change
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                gen_cnt_ff[i] <= 10'h000;
                gen_sel_ff[i] <= 3'h0;
            end
        end
        else if (pll_locked)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (gen_cnt_ff[i] == period_of(gen_sel_ff[i]) - 10'h001)
                begin
                    gen_cnt_ff[i] <= 10'h000;
                    gen_sel_ff[i] <= nxt_sel[i];
                end
                else
                    gen_cnt_ff[i] <= gen_cnt_ff[i] + 10'h001;
            end
        end
        else
            for (int i = 0; i < 3; i++) // halted: restart at count zero, no short phase
            begin
                gen_cnt_ff[i] <= 10'h000;
                gen_sel_ff[i] <= nxt_sel[i];
            end
    end

    // clock levels: first phase fixed length, second phase stretched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clocks <= '0;
        else
        begin
            // timer base never stops for lock; it follows the osc, or the osc over 128 when the strap sets timer prescale
            clocks.timer_base_clock <= cfg_ff.timer_prescale ?
                pre_cnt_ff[`PRESCALE_BITS-1] : osc_sync_ff[1];
            if (pll_locked)
            begin
                // system is vco/4 at divide by one
                clocks.general_system_clock <= gen_cnt_ff[0] < 10'(`KEEP_PHASE);
                clocks.integration_module_clock <= gen_cnt_ff[0] < 10'(`KEEP_PHASE);
                clocks.clock_out_single <= gen_cnt_ff[0] < 10'(`KEEP_PHASE);
                clocks.clock_out_double <= ~gen_cnt_ff[0][0]
                    && gen_cnt_ff[0] < 10'(`BASE_PERIOD);
                clocks.baud_gen_clock <= gen_cnt_ff[1] < 10'(`KEEP_PHASE);
                clocks.serial_sync_clock <= gen_cnt_ff[2] < 10'(`KEEP_PHASE);
            end
            else
            begin
                // halted while acquiring lock
                clocks.general_system_clock <= 1'b0;
                clocks.integration_module_clock <= 1'b0;
                clocks.clock_out_single <= 1'b0;
                clocks.clock_out_double <= 1'b0;
                clocks.baud_gen_clock <= 1'b0;
                clocks.serial_sync_clock <= 1'b0;
            end
        end
    end

endmodule

//--- tb/clkgen_checker.sv
// port assertions for the clock generator
`timescale 1ns/1ps
module clkgen_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire clkgen_pkg::clocks_t clocks,
    input wire logic pll_locked
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completed apb transfer
    logic done;
    assign done = psel & penable & pready;

    a_single_eq_sys:
        assert property (clocks.clock_out_single == clocks.general_system_clock)
        else $error("single output differs from system clock");
    a_module_eq_sys:
        assert property (clocks.integration_module_clock == clocks.general_system_clock)
        else $error("module clock differs from system clock");
    // phase checks pause while unlocked, since a halt may cut a phase short
    a_high_phase:
        assert property (disable iff (!presetn || !pll_locked)
            $rose(clocks.general_system_clock) |->
            clocks.general_system_clock [*2] ##1 !clocks.general_system_clock)
        else $error("system clock high phase not two cycles");
    a_low_phase:
        assert property (disable iff (!presetn || !pll_locked)
            $fell(clocks.general_system_clock) |-> !clocks.general_system_clock [*2])
        else $error("system clock low phase too short");
    a_double_rate:
        assert property (disable iff (!presetn || !pll_locked)
            $rose(clocks.clock_out_single) |->
            clocks.clock_out_double ##1 !clocks.clock_out_double ##1 clocks.clock_out_double)
        else $error("double output not at twice the rate");
    a_halt_unlocked:
        assert property (!pll_locked && !$past(pll_locked) |-> !clocks.general_system_clock)
        else $error("system clock runs without lock");
    a_write_drops_lock:
        assert property (done && pwrite && paddr == 12'h000 && pwdata[12] && pll_locked
            |-> ##[1:2] !pll_locked)
        else $error("multiply write kept lock");
    a_relock_bound:
        assert property ($fell(pll_locked) |-> ##[1:200] pll_locked)
        else $error("lock not regained");
    a_unmapped_err:
        assert property (done |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
        else $error("error response wrong for address");

    c_pll_write: cover property (done && pwrite && paddr == 12'h000);
    c_relock: cover property ($rose(pll_locked));
    c_refused: cover property (done && pslverr);
endmodule

//--- tb/osc_model.sv
// crystal oscillator and mode strap pins seen by the clock generator
`timescale 1ns/1ps
module osc_model (
    input wire logic [1:0] mode_sel,
    output logic osc_input_pin,
    output logic [1:0] clock_mode_pins
);
    // 30 ns period, well under pclk/4, keeps the reference sane
    // free running: a crystal never stops; offset keeps edges off pclk
    initial
    begin
        osc_input_pin = 1'h0;
        #1;
        forever #15 osc_input_pin = ~osc_input_pin;
    end

    // straps are held by the board; the device samples them once, just after reset release
    assign clock_mode_pins = mode_sel;
endmodule

//--- tb/testbench.sv
// self-checking testbench for the clock generator
`timescale 1ns/1ps
module testbench;
    localparam int LIM = 8000;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic osc_input_pin;
    logic [1:0] clock_mode_pins;
    logic [1:0] mode_sel = 2'h0;
    logic [2:0] interrupt_level = 3'h0;
    logic risc_busy = 1'h0;
    clkgen_pkg::clocks_t clocks;
    logic pll_locked;
    logic [31:0] rd;
    logic er;
    int failures = 0;
    int comparisons = 0;
    int p;

    always #2.5 pclk = ~pclk;

    pll_clock_generator_slowgo #(.LOCK_CLOCKS(4)) pll_clock_generator_slowgo_inst (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .osc_input_pin, .clock_mode_pins, .interrupt_level, .risc_busy, .clocks, .pll_locked);
    osc_model osc_model_inst (.mode_sel, .osc_input_pin, .clock_mode_pins);

    task automatic end_of_test;
        if (failures == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick;
        @(posedge pclk);
        p++;
    endtask

    // a wait that ran out ends the run at once
    task automatic guard(input string what);
        if (p >= LIM)
        begin
            chk(what, 32'h0, 32'h1);
            end_of_test;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        p = 0;
        do
            tick;
        while (pready !== 1'h1 && p < LIM);
        guard("apb answer");
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // rise to rise of one derived clock; first pass absorbs a ratio change
    task automatic period(input int b);
        repeat (2)
        begin
            p = 0;
            while (clocks[b] === 1'h1 && p < LIM) tick;
            while (clocks[b] !== 1'h1 && p < LIM) tick;
            p = 0;
            while (clocks[b] === 1'h1 && p < LIM) tick;
            while (clocks[b] !== 1'h1 && p < LIM) tick;
            guard("clock period");
        end
    endtask

    task automatic wait_lock;
        p = 0;
        while (pll_locked !== 1'h1 && p < LIM) tick;
        guard("lock");
    endtask

    task automatic do_reset(input logic [1:0] m);
        mode_sel <= m;
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        wait_lock;
    endtask

    // every strap code; multiply left alone as software must
    task automatic t_modes;
        logic [11:0] fld [4] = '{12'h190, 12'h001, 12'h190, 12'h001};
        int dv [4] = '{1, 128, 128, 1};
        for (int m = 0; m < 4; m++)
        begin
            do_reset(m[1:0]);
            apb(1'h0, 12'h000, 32'h0);
            chk("multiply field", fld[m], rd[11:0]);
            mode_sel <= ~m[1:0];
            apb(1'h0, 12'h008, 32'h0);
            chk("captured mode", m, rd[5:4]);
            period(2);
            chk("timer period", 6 * dv[m], p);
        end
    endtask

    task automatic t_defaults;
        apb(1'h0, 12'h004, 32'h0);
        chk("divider reset", 32'h0, rd);
        for (int b = 0; b < 7; b++)
        begin
            if (b != 2)
            begin
                period(b);
                chk("derived period", (b == 0) ? 2 : 4, p);
            end
        end
    endtask

    // forced low, automatic high on irq or busy risc, back to low, normal
    task automatic t_slowgo;
        logic [31:0] dv [7] = '{32'h0000_0082, 32'h0000_8292, 32'h0000_8292,
            32'h0000_8A92, 32'h0000_8A92, 32'h0000_0A92, 32'h0000_0000};
        logic [2:0] il [7] = '{3'h0, 3'h3, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
        logic bz [7] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0};
        int ex [7] = '{16, 8, 16, 8, 16, 4, 4};
        for (int i = 0; i < 7; i++)
        begin
            apb(1'h1, 12'h004, dv[i]);
            interrupt_level <= il[i];
            risc_busy <= bz[i];
            period(6);
            chk("system period", ex[i], p);
        end
    endtask

    task automatic t_sync_baud;
        apb(1'h1, 12'h004, 32'h0002_1000);
        period(4);
        chk("sync period", 32'h8, p);
        period(5);
        chk("baud period", 32'h10, p);
        period(6);
        chk("system period", 32'h4, p);
    endtask

    // extreme factors 4096 and 1
    task automatic t_pll;
        logic [31:0] v [2] = '{32'h0000_1FFF, 32'h0000_1000};
        for (int i = 0; i < 2; i++)
        begin
            apb(1'h1, 12'h000, v[i]);
            repeat (2) @(posedge pclk);
            chk("lock after write", 32'h0, pll_locked);
            wait_lock;
            apb(1'h0, 12'h000, 32'h0);
            chk("multiply readback", v[i], rd);
        end
    endtask

    task automatic t_unmapped;
        apb(1'h1, 12'h00C, 32'hFFFF_FFFF);
        chk("unmapped error", 32'h1, er);
        apb(1'h0, 12'h00C, 32'h0);
        chk("unmapped data", 32'h0, rd);
        apb(1'h1, 12'h008, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        chk("status locked", 32'h1, rd[0]);
    endtask

    task automatic t_protect;
        apb(1'h1, 12'h004, 32'h8000_0082);
        apb(1'h1, 12'h004, 32'h0000_0000);
        apb(1'h0, 12'h004, 32'h0);
        chk("protected divider", 32'h8000_0082, rd);
        period(6);
        chk("protected period", 32'h10, p);
    endtask

    initial
    begin
        t_modes;
        do_reset(2'h0);
        t_defaults;
        t_slowgo;
        t_sync_baud;
        t_pll;
        t_unmapped;
        t_protect;
        end_of_test;
    end
endmodule

bind pll_clock_generator_slowgo clkgen_checker clkgen_checker_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .clocks, .pll_locked);
